// ===== core/tcc_pkg.sv
// Package for the 16-bit timer with capture/compare channel 0
package tcc_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [15:0] TCC_OFS_COUNT = 16'hFF12;
    localparam logic [15:0] TCC_OFS_CC0 = 16'hFF14;
    localparam logic [15:0] TCC_OFS_MODE = 16'hFF60;
    localparam logic [15:0] TCC_OFS_CCCTL = 16'hFF64;
    localparam logic [15:0] TCC_OFS_PRESC = 16'hFF68;
    localparam logic [15:0] TCC_OFS_TRIG = 16'hFF6C;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TCC_MODE_OVF = 0;
    localparam int TCC_MODE_LO = 1;
    localparam int TCC_MODE_HI = 3;
    localparam int TCC_CC_CAPEN = 0;
    localparam int TCC_CC_SRC = 1;
    localparam int TCC_CC_PINOUT = 2;
    localparam int TCC_PR_E0_LO = 4;
    localparam int TCC_PR_E1_LO = 6;
    localparam int TCC_TRIG_ONESHOT = 0;
    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [15:0] TCC_RST_COUNT = 16'h0000;
    localparam logic [15:0] TCC_RST_CC0 = 16'h0000;
    localparam logic [7:0] TCC_RST_BYTE = 8'h00;
    localparam logic [1:0] TCC_OP_STOP = 2'h0;
    localparam logic [1:0] TCC_OP_FREE = 2'h1;
    localparam logic [1:0] TCC_OP_EDGE = 2'h2;
    localparam logic [1:0] TCC_OP_MATCH = 2'h3;
    localparam logic [1:0] TCC_EDGE_FALL = 2'h0;
    localparam logic [1:0] TCC_EDGE_RISE = 2'h1;
    localparam logic [1:0] TCC_EDGE_BOTH = 2'h3;
    localparam logic [15:0] TCC_ADDR_HI_ZERO = 16'h0000;
endpackage

// ===== core/tcc_core.sv
// 16-bit timer/event counter with one capture/compare channel and Avalon-MM slave
`timescale 1ns/1ns

// Overview of operation
// RULE1: Counter adds one per count clock edge while operating.
// RULE2: Counter reads freeze counting that cycle; missed pulse added next cycle.
// RULE3: Counter cleared at reset and when mode bits 3:2 are zero.
// RULE4: Counter cleared on input 0 edge or register 0 match per mode.
// RULE5: One-shot trigger write of 1 clears the counter.
// RULE6: Counter reads never capture into register 1.
// RULE7: Control bit 0 picks capture or compare for register 0.
// RULE8: Register 0 is 16-bit read/write, reset to zero.
// RULE9: Compare mode raises match interrupt when counter equals register 0.
// RULE10: Control bit 1 picks input 0 or input 1 as capture source.
// RULE11: Input 0 edge field; capture on opposite edge; both means none.
// RULE12: Input 1 edge field; capture on the selected edge.
// RULE13: Software never writes edge code 1,0.
// RULE14: Software keeps register 0 nonzero in match-clear mode.
// RULE15: Compare value zero matches after wrap, on step to 0001H.
// RULE16: Lower compare value means counting through overflow first.
// RULE17: No capture while register 0 is in compare mode.
// RULE18: Capture stores correctly even when a read coincides.
// RULE19: Shared pin is either input 1 or timer output.
// RULE20: External pulses hold each level at least two clocks.
// RULE21: Intervals from 2 to 65536 count clocks.
// RULE22: Pulse width above one, below cycle, cycle up to 65536.
// RULE23: Mode bits select stop, free-run, edge-clear, match-clear.
// RULE24: Overflow flag set on counter wrap, reads 0 otherwise.
// RULE25: Counter wraps FFFFH to 0000H and keeps counting.
module tcc_core #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Count clock enable from prescaler
    input wire logic count_tick,
    // Avalon-MM slave
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Timer pins
    input wire logic timer_input_0,
    input wire logic timer_input_1,
    input wire logic timer_output_value,
    output logic shared_port_pin_out,
    output logic shared_port_pin_oe,
    // Events
    output logic channel0_match_irq,
    output logic channel0_capture_irq
);
    import tcc_pkg::*;

    initial begin
        if (CNT_W != 16) begin
            $error("tcc_core supports only a 16-bit counter");
        end
        // The edge fields are packed side by side in one byte
        if (TCC_PR_E1_LO != TCC_PR_E0_LO + 2) begin
            $error("tcc_core edge fields overlap");
        end
    end

    typedef struct packed {
        // Registers seen by software
        logic [15:0] main_counter;
        logic [15:0] capture_compare_register_0;
        logic [7:0] mode_control_reg;
        logic [7:0] cc_control_reg;
        logic [7:0] prescaler_mode_reg;
        // Pin and event state
        logic pend_tick;
        // Two flops per pin; bit 0 is the first stage and is read by nothing else
        logic [1:0] in0_sync;
        logic [1:0] in1_sync;
        logic in0_prev;
        logic in1_prev;
        logic match_irq;
        logic capture_irq;
        // Bus answer
        logic ack;
        logic [31:0] rdata;
    } tcc_state_t;

    tcc_state_t cur;
    tcc_state_t next_st;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel, input logic prv, input logic now);
        logic rise;
        logic fall;
        rise = now & ~prv;
        fall = prv & ~now;
        case (sel)
            TCC_EDGE_FALL: begin
                edge_hit = fall;
            end
            TCC_EDGE_RISE: begin
                edge_hit = rise;
            end
            TCC_EDGE_BOTH: begin
                edge_hit = rise | fall;
            end
            // The prohibited code selects no edge here; the input 0 capture path turns it into a rising-edge capture
            default: begin
                edge_hit = 1'b0;
            end
        endcase
    endfunction

    function automatic logic is_reg(input logic [15:0] a, input logic [15:0] ofs);
        is_reg = (a == ofs);
    endfunction

    // True when a step of the counter passes through FFFFH
    function automatic logic wraps(input logic [15:0] from, input logic [15:0] to);
        wraps = (to < from);
    endfunction

    // Read mux; unmapped offsets and the write-only trigger read as zero
    function automatic logic [31:0] read_word(input tcc_state_t s, input logic [15:0] a);
        read_word = 32'h0000_0000;
        case (a)
            TCC_OFS_COUNT: begin
                read_word = {16'h0000, s.main_counter};
            end
            TCC_OFS_CC0: begin
                read_word = {16'h0000, s.capture_compare_register_0};
            end
            TCC_OFS_MODE: begin
                read_word = {24'h000000, s.mode_control_reg};
            end
            TCC_OFS_CCCTL: begin
                read_word = {24'h000000, s.cc_control_reg};
            end
            TCC_OFS_PRESC: begin
                read_word = {24'h000000, s.prescaler_mode_reg};
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    endfunction

    // Decoded fields and pin edges
    logic [1:0] op;
    logic [1:0] e0_sel;
    logic [1:0] e1_sel;
    logic in0_now;
    logic in1_now;
    logic in0_edge;
    logic in1_edge;
    logic cap_edge;

    // Counter and bus strobes
    logic counting;
    logic do_tick;
    logic rd_cnt;
    logic wr_cc0;
    logic wr_mode;
    logic oneshot;
    logic match;

    // Arithmetic and mode write helpers
    logic [15:0] cnt_inc;
    logic mode_zero;
    logic [7:0] wmode;

    always_comb begin
        next_st = cur;
        op = cur.mode_control_reg[TCC_MODE_HI:TCC_MODE_HI-1];
        e0_sel = cur.prescaler_mode_reg[TCC_PR_E0_LO+1:TCC_PR_E0_LO];
        e1_sel = cur.prescaler_mode_reg[TCC_PR_E1_LO+1:TCC_PR_E1_LO];
        in0_now = cur.in0_sync[1];
        in1_now = cur.in1_sync[1];
        in0_edge = edge_hit(e0_sel, cur.in0_prev, in0_now);
        in1_edge = edge_hit(e1_sel, cur.in1_prev, in1_now);

        // ------------------------------------------------------------
        // Strobes
        // ------------------------------------------------------------
        // A counter read freezes counting at the edge where the request is taken
        rd_cnt = avs_read & is_reg(avs_address, TCC_OFS_COUNT) & ~cur.ack;
        // Writes land at the edge where waitrequest is low, never earlier, so a
        // master that retracts a request during the wait state changes nothing
        wr_cc0 = avs_write & cur.ack & is_reg(avs_address, TCC_OFS_CC0)
            & (avs_byteenable[1:0] == 2'h3);
        wr_mode = avs_write & cur.ack & is_reg(avs_address, TCC_OFS_MODE)
            & avs_byteenable[0];
        oneshot = avs_write & cur.ack & is_reg(avs_address, TCC_OFS_TRIG)
            & avs_byteenable[0] & avs_writedata[TCC_TRIG_ONESHOT];
        wmode = avs_writedata[7:0];

        // ------------------------------------------------------------
        // Synchronisers
        // ------------------------------------------------------------
        next_st.in0_sync = {cur.in0_sync[0], timer_input_0};
        next_st.in1_sync = {cur.in1_sync[0], timer_input_1};
        next_st.in0_prev = in0_now;
        next_st.in1_prev = in1_now;
        // RULE19: pin role exclusive
        in1_edge = in1_edge & ~cur.cc_control_reg[TCC_CC_PINOUT];

        // ------------------------------------------------------------
        // Counter
        // ------------------------------------------------------------
        counting = (op != TCC_OP_STOP);
        // RULE2: hold during read
        do_tick = counting & (count_tick | cur.pend_tick) & ~rd_cnt;
        next_st.pend_tick = counting & rd_cnt & (count_tick | cur.pend_tick);
        // RULE1: increment
        // RULE25: wrap and continue
        // A tick held over from a read cycle adds on top of a fresh tick, so a
        // read never costs a count pulse
        cnt_inc = cur.main_counter + 16'h0001 + {15'h0000, count_tick & cur.pend_tick};

        // ------------------------------------------------------------
        // Compare
        // ------------------------------------------------------------
        // RULE16: a compare value below the count is met only after the wrap
        // RULE22: compare points set the pulse cycle for the outside output stage
        // RULE9: compare match
        // RULE15: zero compare matches on 0001H step after wrap
        match = ~cur.cc_control_reg[TCC_CC_CAPEN] & counting
            & (cur.main_counter == cur.capture_compare_register_0) & do_tick;
        if (cur.capture_compare_register_0 == TCC_RST_CC0 && op != TCC_OP_MATCH) begin
            match = ~cur.cc_control_reg[TCC_CC_CAPEN] & do_tick
                & (cur.main_counter == 16'h0000) & cur.mode_control_reg[TCC_MODE_OVF];
        end
        if (do_tick) begin
            next_st.main_counter = cnt_inc;
            // RULE24: overflow flag
            if (wraps(cur.main_counter, cnt_inc)) begin
                next_st.mode_control_reg[TCC_MODE_OVF] = 1'b1;
            end
        end
        // RULE21: match clear gives intervals of compare value plus one ticks
        // RULE4: clear on edge or match
        if ((op == TCC_OP_EDGE && in0_edge) || (op == TCC_OP_MATCH && match)) begin
            next_st.main_counter = TCC_RST_COUNT;
        end
        // RULE5: one-shot clear
        if (oneshot && counting) begin
            next_st.main_counter = TCC_RST_COUNT;
        end
        next_st.match_irq = match;

        // ------------------------------------------------------------
        // Capture
        // ------------------------------------------------------------
        // RULE10: source select
        // RULE11: opposite edge of input 0
        // RULE12: selected edge of input 1
        if (cur.cc_control_reg[TCC_CC_SRC]) begin
            cap_edge = (e0_sel == TCC_EDGE_BOTH) ? 1'b0
                : edge_hit(~e0_sel & 2'h1, cur.in0_prev, in0_now);
        end else begin
            cap_edge = in1_edge;
        end
        // RULE7: capture or compare
        // RULE17: no capture in compare mode
        cap_edge = cap_edge & cur.cc_control_reg[TCC_CC_CAPEN] & counting;
        next_st.capture_irq = cap_edge;

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        // RULE8: 16-bit access only
        if (wr_cc0) begin
            next_st.capture_compare_register_0 = avs_writedata[15:0];
        end
        // RULE18: capture wins over a coinciding access
        // RULE6: only the hardware trigger captures
        if (cap_edge) begin
            next_st.capture_compare_register_0 = cur.main_counter;
        end
        if (wr_mode) begin
            // RULE23: mode select
            next_st.mode_control_reg = {4'h0, wmode[3:1],
                wmode[TCC_MODE_OVF] & cur.mode_control_reg[TCC_MODE_OVF]};
            // Set wins over a clearing write in the same cycle
            if (do_tick && wraps(cur.main_counter, cnt_inc)) begin
                next_st.mode_control_reg[TCC_MODE_OVF] = 1'b1;
            end
            mode_zero = (wmode[TCC_MODE_HI:TCC_MODE_HI-1] == TCC_OP_STOP);
            // RULE3: stop clears counter
            if (mode_zero) begin
                next_st.main_counter = TCC_RST_COUNT;
                next_st.pend_tick = 1'b0;
            end
        end else begin
            mode_zero = 1'b0;
        end
        if (avs_write && cur.ack && avs_byteenable[0]) begin
            if (is_reg(avs_address, TCC_OFS_CCCTL)) begin
                next_st.cc_control_reg = {5'h00, avs_writedata[2:0]};
            end
            if (is_reg(avs_address, TCC_OFS_PRESC)) begin
                next_st.prescaler_mode_reg = {avs_writedata[7:4], 4'h0};
            end
        end
        // ------------------------------------------------------------
        // Bus answer: one wait cycle, then ack
        // Read data is latched as the request is taken and stands until the next one
        // ------------------------------------------------------------
        next_st.ack = (avs_read | avs_write) & ~cur.ack;
        if ((avs_read | avs_write) && !cur.ack) begin
            next_st.rdata = 32'h0000_0000;
            if (avs_read) begin
                next_st.rdata = read_word(cur, avs_address);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur <= '0;
        end else begin
            cur <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_waitrequest = (avs_read | avs_write) & ~cur.ack;
    assign avs_readdata = cur.rdata;
    assign channel0_match_irq = cur.match_irq;
    assign channel0_capture_irq = cur.capture_irq;

    // The pin is driven only in its output role; input 1 edges are masked then
    assign shared_port_pin_out = timer_output_value;
    assign shared_port_pin_oe = cur.cc_control_reg[TCC_CC_PINOUT];
endmodule

// ===== tb/tcc_properties.sv
// Checker for the timer core bus and event ports
`timescale 1ns/1ns
module tcc_properties (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Bus
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins and events
    input wire logic timer_output_value,
    input wire logic shared_port_pin_out,
    input wire logic shared_port_pin_oe,
    input wire logic channel0_match_irq,
    input wire logic channel0_capture_irq
);
    import tcc_pkg::*;
    logic mapped;
    assign mapped = avs_address inside {TCC_OFS_COUNT, TCC_OFS_CC0, TCC_OFS_MODE,
        TCC_OFS_CCCTL, TCC_OFS_PRESC, TCC_OFS_TRIG};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_req_start;
        $rose(avs_read || avs_write);
    endsequence
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_one_wait_state: assert property (s_req_start |-> s_one_wait)
        else $error("request not answered after one wait");
    a_read_upper_zero: assert property (avs_read && !avs_waitrequest |->
        avs_readdata[31:16] == 16'h0000) else $error("upper read bits set");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && !mapped |->
        avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_pin_value: assert property (shared_port_pin_out == timer_output_value)
        else $error("pin value differs");
    a_oe_by_write: assert property ($changed(shared_port_pin_oe) |->
        $past(avs_write && avs_address == TCC_OFS_CCCTL)) else $error("oe moved alone");
    a_match_pulse: assert property (channel0_match_irq |=> !channel0_match_irq)
        else $error("match pulse too long");
    a_capture_pulse: assert property (channel0_capture_irq |=> !channel0_capture_irq)
        else $error("capture pulse too long");
    a_reset_quiet: assert property ($fell(sys_rst) |-> !channel0_match_irq &&
        !channel0_capture_irq && !shared_port_pin_oe) else $error("outputs busy after reset");
endmodule
bind tcc_core tcc_properties i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_output_value(timer_output_value), .shared_port_pin_out(shared_port_pin_out),
    .shared_port_pin_oe(shared_port_pin_oe), .channel0_match_irq(channel0_match_irq),
    .channel0_capture_irq(channel0_capture_irq));

// ===== tb/tcc_pulse_src.sv
// Pulse source model for the two timer input pins
`timescale 1ns/1ns
module tcc_pulse_src (
    // Clock
    input wire logic sys_clk,
    // Pins
    output logic timer_input_0,
    output logic timer_input_1
);
    initial begin
        timer_input_0 = 1'b0;
        timer_input_1 = 1'b0;
    end
    task automatic drive(input bit sel, input logic lvl);
        @(posedge sys_clk);
        if (sel) begin
            timer_input_1 <= lvl;
        end else begin
            timer_input_0 <= lvl;
        end
        repeat (3) @(posedge sys_clk);
    endtask
endmodule

// ===== tb/timer16_capture_compare_core_tb.sv
// Self-checking bench for the 16-bit timer core
`timescale 1ns/1ns
module timer16_capture_compare_core_tb;
    import tcc_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic count_tick = 1'b0;
    logic [15:0] avs_address = 16'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic timer_input_0;
    logic timer_input_1;
    logic timer_output_value = 1'b1;
    logic pin_out;
    logic pin_oe;
    logic match_irq;
    logic cap_irq;
    int mismatches = 0;
    int checked = 0;
    int n_match = 0;
    int n_cap = 0;
    logic [31:0] q;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        n_match += int'(match_irq === 1'b1);
        n_cap += int'(cap_irq === 1'b1);
    end
    tcc_core i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .count_tick(count_tick),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer_input_0(timer_input_0),
        .timer_input_1(timer_input_1), .timer_output_value(timer_output_value),
        .shared_port_pin_out(pin_out), .shared_port_pin_oe(pin_oe),
        .channel0_match_irq(match_irq), .channel0_capture_irq(cap_irq));
    tcc_pulse_src i_src (.sys_clk(sys_clk), .timer_input_0(timer_input_0),
        .timer_input_1(timer_input_1));
    // ----
    // Shared tasks
    // ----
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k >= 50) begin
            chk("bus timeout", 0, 1);
            close_out();
        end
    endtask
    task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            count_tick <= 1'b1;
        end
        @(posedge sys_clk);
        count_tick <= 1'b0;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        rchk("count", TCC_OFS_COUNT, 32'h0);
        rchk("cc0", TCC_OFS_CC0, 32'h0);
        rchk("unmapped", 16'hFF00, 32'h0);
        bus(1'b1, TCC_OFS_CC0, 32'hA5C3);
        rchk("cc0 rw", TCC_OFS_CC0, 32'hA5C3);
        $display("t_regs done");
    endtask
    task automatic t_count();
        bus(1'b1, TCC_OFS_MODE, 32'h4);
        ticks(7);
        rchk("count", TCC_OFS_COUNT, 32'h7);
        fork
            ticks(9);
            repeat (3) bus(1'b0, TCC_OFS_COUNT, 32'h0);
        join
        rchk("count read", TCC_OFS_COUNT, 32'h10);
        bus(1'b1, TCC_OFS_TRIG, 32'h1);
        rchk("one shot", TCC_OFS_COUNT, 32'h0);
        ticks(3);
        bus(1'b1, TCC_OFS_MODE, 32'h0);
        ticks(4);
        rchk("stopped", TCC_OFS_COUNT, 32'h0);
        $display("t_count done");
    endtask
    task automatic t_match();
        int m0;
        m0 = n_match;
        bus(1'b1, TCC_OFS_CC0, 32'h5);
        bus(1'b1, TCC_OFS_MODE, 32'hC);
        ticks(13);
        rchk("match clear", TCC_OFS_COUNT, 32'h1);
        chk("matches", 32'd2, n_match - m0);
        $display("t_match done");
    endtask
    task automatic t_ovf();
        int m0;
        bus(1'b1, TCC_OFS_MODE, 32'h0);
        bus(1'b1, TCC_OFS_CC0, 32'h0);
        bus(1'b1, TCC_OFS_MODE, 32'h4);
        m0 = n_match;
        ticks(65538);
        rchk("ovf flag", TCC_OFS_MODE, 32'h5);
        rchk("wrap", TCC_OFS_COUNT, 32'h2);
        chk("zero match", 32'd1, n_match - m0);
        $display("t_ovf done");
    endtask
    task automatic t_cap();
        int c0;
        c0 = n_cap;
        bus(1'b1, TCC_OFS_MODE, 32'h0);
        bus(1'b1, TCC_OFS_MODE, 32'h4);
        ticks(3);
        bus(1'b1, TCC_OFS_CCCTL, 32'h1);
        bus(1'b1, TCC_OFS_PRESC, 32'h40);
        i_src.drive(1'b1, 1'b1);
        rchk("in1 rise", TCC_OFS_CC0, 32'h3);
        ticks(2);
        i_src.drive(1'b1, 1'b0);
        rchk("in1 fall", TCC_OFS_CC0, 32'h3);
        bus(1'b1, TCC_OFS_CCCTL, 32'h3);
        bus(1'b1, TCC_OFS_PRESC, 32'h10);
        i_src.drive(1'b0, 1'b1);
        ticks(1);
        i_src.drive(1'b0, 1'b0);
        rchk("in0 opposite", TCC_OFS_CC0, 32'h6);
        bus(1'b1, TCC_OFS_PRESC, 32'h30);
        i_src.drive(1'b0, 1'b1);
        rchk("in0 both", TCC_OFS_CC0, 32'h6);
        chk("captures", 32'd2, n_cap - c0);
        bus(1'b1, TCC_OFS_CCCTL, 32'h4);
        @(posedge sys_clk);
        chk("pin oe", 32'h1, {31'h0, pin_oe});
        $display("t_cap done");
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_count();
        t_match();
        t_ovf();
        t_cap();
        close_out();
    end
endmodule
